// >>> src/arbt_consts.vh
// constants for the playback trigger control block
`ifndef ARBT_CONSTS_VH
`define ARBT_CONSTS_VH

// ***********************************
// register offsets (byte addresses)
// ***********************************
`define ARBT_ADDR_CTRL     8'h00
`define ARBT_ADDR_EXT_RATE 8'h04
`define ARBT_ADDR_CMD      8'h08
`define ARBT_ADDR_STATUS   8'h0C
`define ARBT_ADDR_RATE     8'h10

// ***********************************
// control register fields
// ***********************************
`define ARBT_F_MODE        0
`define ARBT_F_CONT_RESP   2
`define ARBT_F_SINGLE_RESP 4
`define ARBT_F_STEP        6
`define ARBT_F_GATE_LVL    7
`define ARBT_F_SRC         8
`define ARBT_F_CLK_EXT     10
`define ARBT_CTRL_BITS     11
`define ARBT_CTRL_RESET    11'h000

// command register bits
`define ARBT_F_CMD_TRIG    0
`define ARBT_F_CMD_LOAD    1

// ***********************************
// codes
// ***********************************
`define ARBT_MODE_CONT     2'h0
`define ARBT_MODE_SINGLE   2'h1
`define ARBT_MODE_SEG      2'h2
`define ARBT_MODE_GATE     2'h3
`define ARBT_RESP_AUTO     2'h0
`define ARBT_RESP_TRIG     2'h1
`define ARBT_RESP_RESTART  2'h2
`define ARBT_SRC_KEY       2'h0
`define ARBT_SRC_BUS       2'h1
`define ARBT_SRC_EXT       2'h2
`define ARBT_SRC_INT       2'h3

// ***********************************
// sample rates in Hz
// ***********************************
`define ARBT_INT_RATE      32'h0BEBC200
`define ARBT_EXT_RATE_RST  32'h0BEBC200
`define ARBT_EXT_RATE_MIN  32'h00000064
`define ARBT_EXT_RATE_MAX  32'h0EE6B280

`endif

// >>> src/arbt_trigger_ctrl.v
// playback trigger control with sample FIFO
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "arbt_consts.vh"

// ***********************************
// sample FIFO
// ***********************************
module arbt_fifo
#(
	parameter WIDTH = 18,
	parameter DEPTH = 16,
	parameter AW    = 4
)
(
	input  wire             clock_i,
	input  wire             reset_n_i,
	input  wire             flush_i,
	input  wire [WIDTH-1:0] wr_data_i,
	input  wire             wr_valid_i,
	output wire             wr_ready_o,
	output wire [WIDTH-1:0] rd_data_o,
	output wire             rd_valid_o,
	input  wire             rd_ready_i
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_reg;
	reg  [AW-1:0]    rd_ptr_reg;
	reg  [AW:0]      count_reg;
	reg  [AW:0]      count_next;
	reg              ready_reg;
	wire             push;
	wire             pop;

	assign push       = wr_valid_i && ready_reg && !flush_i;
	assign pop        = rd_ready_i && (count_reg != {(AW+1){1'b0}}) && !flush_i;
	assign wr_ready_o = ready_reg;
	assign rd_valid_o = (count_reg != {(AW+1){1'b0}});
	assign rd_data_o  = mem[rd_ptr_reg];

	always @*
	begin
		count_next = count_reg;
		if (flush_i)
			count_next = {(AW+1){1'b0}};
		else if (push && !pop)
			count_next = count_reg + 1'b1;
		else if (pop && !push)
			count_next = count_reg - 1'b1;
	end

	always @(posedge clock_i)
	begin
		if (push)
			mem[wr_ptr_reg] <= wr_data_i;
	end

	// ready is registered so the source sees a clean flop
	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
			ready_reg  <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			ready_reg <= (count_next != DEPTH[AW:0]);
			if (flush_i)
			begin
				wr_ptr_reg <= {AW{1'b0}};
				rd_ptr_reg <= {AW{1'b0}};
			end
			else
			begin
				if (push)
					wr_ptr_reg <= wr_ptr_reg + 1'b1;
				if (pop)
					rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule // arbt_fifo

// Notes on behaviour
// - auto-run starts after load, ignores triggers
// - wait mode: trigger plays once, then waits
// - restart mode: silent until trigger, then loops
// - restart mode: trigger aborts and restarts
// - separate continuous and single sub-modes, reset auto
// - segment stepping single or continuous, reset single
// - gate active level low or high, reset low
// - trigger source key, bus, external, internal
// - internal sample clock fixed at 200 MHz
// - external rate 100Hz..250MHz, reset 200MHz
// - continuous mode plays sequence repeatedly
// - single mode plays once per trigger
// - segment mode plays one segment per trigger
// - gate mode plays while gate active
module arbt_trigger_ctrl
(
	input  wire        clock_i,
	input  wire        reset_n_i,
	input  wire [7:0]  reg_addr_i,
	input  wire [31:0] reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [31:0] reg_rdata_o,
	input  wire        trig_key_i,
	input  wire        trig_ext_i,
	input  wire        trig_int_i,
	input  wire        gate_i,
	input  wire [15:0] src_data_i,
	input  wire        src_seg_end_i,
	input  wire        src_seq_end_i,
	input  wire        src_valid_i,
	output wire        src_ready_o,
	output reg  [15:0] smp_data_o,
	output reg         smp_valid_o,
	input  wire        smp_ready_i,
	output reg         rewind_o,
	output reg         playing_o,
	output reg         clk_ext_sel_o,
	output reg  [31:0] smp_rate_o
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_PLAY = 2'h2;
	localparam ST_DONE = 2'h3;

	reg  [`ARBT_CTRL_BITS-1:0] ctrl_reg;
	reg  [31:0]                ext_rate_reg;
	reg                        loaded_reg;
	reg  [1:0]                 state_reg;
	reg  [1:0]                 state_next;
	reg                        rewind_next;
	reg  [2:0]                 sync1_reg;
	reg  [2:0]                 sync2_reg;
	reg  [2:0]                 sync3_reg;
	reg  [2:0]                 stable_reg;
	reg  [2:0]                 stable_next;
	reg                        int_prev_reg;
	reg                        bus_trig_reg;
	reg                        trig_reg;
	reg                        trig_next;
	reg  [1:0]                 resp;
	wire [1:0]                 mode;
	wire                       step_cont;
	wire                       gate_act;
	wire                       wr_ctrl;
	wire                       wr_cmd;
	wire                       cfg_change;
	wire                       load_cmd;
	wire [17:0]                fifo_data;
	wire                       fifo_valid;
	wire                       take;
	wire                       seq_end;
	wire                       seg_end;

	assign mode      = ctrl_reg[`ARBT_F_MODE+1:`ARBT_F_MODE];
	assign step_cont = ctrl_reg[`ARBT_F_STEP];
	assign wr_ctrl   = reg_wr_i && (reg_addr_i == `ARBT_ADDR_CTRL);
	assign wr_cmd    = reg_wr_i && (reg_addr_i == `ARBT_ADDR_CMD);
	assign load_cmd  = wr_cmd && reg_wdata_i[`ARBT_F_CMD_LOAD];
	// sample clock selection alone does not disturb the player
	assign cfg_change = wr_ctrl &&
		(reg_wdata_i[`ARBT_F_CLK_EXT-1:0] != ctrl_reg[`ARBT_F_CLK_EXT-1:0]);
	// gate level, active low or high
	assign gate_act = ctrl_reg[`ARBT_F_GATE_LVL] ? stable_reg[2] : !stable_reg[2];

	// ***********************************
	// pin synchronisers: key, ext, gate
	// ***********************************
	always @*
	begin
		// a bit moves only once the second and third stages agree
		stable_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) |
			(stable_reg & (sync2_reg ^ sync3_reg));
	end

	always @*
	begin
		case (ctrl_reg[`ARBT_F_SRC+1:`ARBT_F_SRC])
			`ARBT_SRC_KEY: trig_next = stable_next[0] && !stable_reg[0];
			`ARBT_SRC_BUS: trig_next = bus_trig_reg;
			`ARBT_SRC_EXT: trig_next = stable_next[1] && !stable_reg[1];
			default:       trig_next = trig_int_i && !int_prev_reg;
		endcase
	end

	// ***********************************
	// sample path
	// ***********************************
	arbt_fifo
	#(
		.WIDTH (18),
		.DEPTH (16),
		.AW    (4)
	)
	u_fifo
	(
		.clock_i    (clock_i),
		.reset_n_i  (reset_n_i),
		.flush_i    (rewind_next),
		.wr_data_i  ({src_seq_end_i, src_seg_end_i, src_data_i}),
		.wr_valid_i (src_valid_i),
		.wr_ready_o (src_ready_o),
		.rd_data_o  (fifo_data),
		.rd_valid_o (fifo_valid),
		.rd_ready_i (take)
	);

	// draining stalls outside play, so the FIFO backs up to the source
	assign take    = (state_reg == ST_PLAY) && fifo_valid && (!smp_valid_o || smp_ready_i);
	assign seq_end = take && fifo_data[17];
	assign seg_end = take && fifo_data[16];

	// ***********************************
	// player state machine
	// ***********************************
	always @*
	begin
		resp = (mode == `ARBT_MODE_SINGLE) ?
			ctrl_reg[`ARBT_F_SINGLE_RESP+1:`ARBT_F_SINGLE_RESP] :
			ctrl_reg[`ARBT_F_CONT_RESP+1:`ARBT_F_CONT_RESP];
		state_next  = state_reg;
		rewind_next = 1'b0;
		case (state_reg)
			ST_IDLE:
			begin
				if (mode == `ARBT_MODE_GATE)
				begin
					if (gate_act)
						state_next = ST_PLAY;
				end
				else if (mode == `ARBT_MODE_SEG)
					state_next = ST_WAIT;
				else if (resp == `ARBT_RESP_AUTO)
				begin
					if (loaded_reg)
						state_next = ST_PLAY;
				end
				else
					state_next = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (trig_reg)
					state_next = ST_PLAY;
			end
			ST_PLAY:
			begin
				case (mode)
					`ARBT_MODE_GATE:
					begin
						// pause in place; resumes where it stopped
						if (!gate_act)
							state_next = ST_IDLE;
					end
					`ARBT_MODE_SEG:
					begin
						if (seg_end && !step_cont)
							state_next = ST_WAIT;
					end
					default:
					begin
						if (resp == `ARBT_RESP_RESTART)
						begin
							if (trig_reg)
								rewind_next = 1'b1;
						end
						else if (resp == `ARBT_RESP_TRIG)
						begin
							if (seq_end)
								state_next = ST_WAIT;
						end
						else if (mode == `ARBT_MODE_SINGLE && seq_end)
							state_next = ST_DONE;
						// continuous auto and restart keep looping
					end
				endcase
			end
			ST_DONE:
				state_next = ST_DONE;
			default:
				state_next = ST_IDLE;
		endcase
		if (cfg_change || load_cmd)
		begin
			state_next  = ST_IDLE;
			rewind_next = 1'b1;
		end
	end

	// ***********************************
	// registers and outputs
	// ***********************************
	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ctrl_reg      <= `ARBT_CTRL_RESET;
			ext_rate_reg  <= `ARBT_EXT_RATE_RST;
			loaded_reg    <= 1'b0;
			state_reg     <= ST_IDLE;
			sync1_reg     <= 3'h0;
			sync2_reg     <= 3'h0;
			sync3_reg     <= 3'h0;
			stable_reg    <= 3'h0;
			int_prev_reg  <= 1'b0;
			bus_trig_reg  <= 1'b0;
			trig_reg      <= 1'b0;
			rewind_o      <= 1'b0;
			playing_o     <= 1'b0;
			clk_ext_sel_o <= 1'b0;
			smp_rate_o    <= `ARBT_INT_RATE;
			smp_data_o    <= 16'h0000;
			smp_valid_o   <= 1'b0;
			reg_rdata_o   <= 32'h00000000;
		end
		else
		begin
			sync1_reg    <= {gate_i, trig_ext_i, trig_key_i};
			sync2_reg    <= sync1_reg;
			sync3_reg    <= sync2_reg;
			stable_reg   <= stable_next;
			int_prev_reg <= trig_int_i;
			bus_trig_reg <= wr_cmd && reg_wdata_i[`ARBT_F_CMD_TRIG];
			// gate mode uses the level only, never the pulse
			trig_reg     <= trig_next && (mode != `ARBT_MODE_GATE);
			state_reg    <= state_next;
			rewind_o     <= rewind_next;
			playing_o    <= (state_next == ST_PLAY);
			if (wr_ctrl)
				ctrl_reg <= reg_wdata_i[`ARBT_CTRL_BITS-1:0];
			// out-of-range rates are dropped, keeping the last good one
			if (reg_wr_i && reg_addr_i == `ARBT_ADDR_EXT_RATE &&
				reg_wdata_i >= `ARBT_EXT_RATE_MIN && reg_wdata_i <= `ARBT_EXT_RATE_MAX)
				ext_rate_reg <= reg_wdata_i;
			if (load_cmd)
				loaded_reg <= 1'b1;
			clk_ext_sel_o <= ctrl_reg[`ARBT_F_CLK_EXT];
			smp_rate_o    <= ctrl_reg[`ARBT_F_CLK_EXT] ?
				ext_rate_reg : `ARBT_INT_RATE;
			if (rewind_next)
				smp_valid_o <= 1'b0;
			else if (take)
			begin
				smp_data_o  <= fifo_data[15:0];
				smp_valid_o <= 1'b1;
			end
			else if (smp_ready_i)
				smp_valid_o <= 1'b0;
			reg_rdata_o <= 32'h00000000;
			if (reg_rd_i)
			begin
				case (reg_addr_i)
					`ARBT_ADDR_CTRL:     reg_rdata_o <= {21'h000000, ctrl_reg};
					`ARBT_ADDR_EXT_RATE: reg_rdata_o <= ext_rate_reg;
					`ARBT_ADDR_STATUS:
						reg_rdata_o <= {26'h0000000, stable_reg, loaded_reg, state_reg};
					`ARBT_ADDR_RATE:     reg_rdata_o <= smp_rate_o;
					default:             reg_rdata_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // arbt_trigger_ctrl

// >>> verification/arbt_asserts.sv
// port checker for the playback trigger control
`timescale 1ns/1ns
module arbt_chk
(
	input wire        clock_i,
	input wire        reset_n_i,
	input wire [7:0]  reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire        reg_wr_i,
	input wire        reg_rd_i,
	input wire [31:0] reg_rdata_o,
	input wire [15:0] smp_data_o,
	input wire        smp_valid_o,
	input wire        smp_ready_i,
	input wire        rewind_o,
	input wire        clk_ext_sel_o,
	input wire [31:0] smp_rate_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	// two cycles of internal select so a rate update lag is tolerated
	int_rate_a: assert property ((!clk_ext_sel_o) [*2] |-> smp_rate_o == 32'h0BEBC200)
		else $error("internal rate wrong");
	rate_span_a: assert property (smp_rate_o >= 32'h00000064 &&
		smp_rate_o <= 32'h0EE6B280) else $error("rate out of range");
	ext_sel_a: assert property (reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[10] |->
		##2 clk_ext_sel_o) else $error("external clock not selected");
	rate_read_a: assert property (reg_rd_i && reg_addr_i == 8'h10 |=>
		reg_rdata_o == $past(smp_rate_o)) else $error("rate readback wrong");
	rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h00000000)
		else $error("read data outside its slot");
	load_rewind_a: assert property (reg_wr_i && reg_addr_i == 8'h08 && reg_wdata_i[1] |->
		##[1:3] rewind_o) else $error("load gave no rewind");
	rewind_drop_a: assert property ($rose(rewind_o) |-> !smp_valid_o)
		else $error("output kept over rewind");
	stall_hold_a: assert property (smp_valid_o && !smp_ready_i |=>
		rewind_o || smp_valid_o && $stable(smp_data_o)) else $error("stalled word lost");
endmodule // arbt_chk

bind arbt_trigger_ctrl arbt_chk i_chk
(
	.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .smp_data_o(smp_data_o), .smp_valid_o(smp_valid_o),
	.smp_ready_i(smp_ready_i), .rewind_o(rewind_o), .clk_ext_sel_o(clk_ext_sel_o),
	.smp_rate_o(smp_rate_o)
);

// >>> verification/arbt_src_model.sv
// datapath model offering a numbered looping sequence of words
`timescale 1ns/1ns
module arbt_src_model
#(
	parameter SEQ = 12,
	parameter SEG = 4
)
(
	input  wire        clock_i,
	input  wire        reset_n_i,
	input  wire        rewind_i,
	input  wire        ready_i,
	output wire [15:0] data_o,
	output wire        valid_o,
	output wire        seg_end_o,
	output wire        seq_end_o
);
	reg  [15:0] idx_reg;
	reg         on_reg;
	wire        last = idx_reg == SEQ - 1;
	// offer withdrawn during a restart; idle lines show inverted values
	assign valid_o   = on_reg && !rewind_i;
	assign data_o    = valid_o ? idx_reg : ~idx_reg;
	assign seg_end_o = (idx_reg % SEG == SEG - 1) ^ !valid_o;
	assign seq_end_o = last ^ !valid_o;
	always @(posedge clock_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			idx_reg <= 16'h0000;
			on_reg <= 1'b0;
		end
		else
		begin
			on_reg <= 1'b1;
			if (rewind_i)
				idx_reg <= 16'h0000;
			else if (valid_o && ready_i)
				idx_reg <= last ? 16'h0000 : idx_reg + 16'h0001;
		end
endmodule // arbt_src_model

// >>> verification/tb.sv
// self-checking bench for the playback trigger control
`timescale 1ns/1ns
module tb;
	localparam SEQ = 12;
	localparam SEG = 4;
	reg         clk = 0, rst_n = 0, we = 0, re = 0, gate = 0, rdy = 0;
	reg  [7:0]  ad = 8'h00;
	reg  [31:0] wd = 32'h00000000, cur = 32'h0BEBC200;
	reg  [3:0]  pin = 4'h0;
	reg  [15:0] exp_idx = 16'h0000;
	reg  [31:0] vals [5];
	wire [31:0] rdata, rate;
	wire [15:0] sdata, smp;
	wire        sval, sseg, sseq, sready, smp_v, rew, play;
	int         bad_count = 0, tests_run = 0, cyc = 0, words = 0, rews = 0, w0, r0, s, i;
	arbt_trigger_ctrl i_dut
	(
		.clock_i(clk), .reset_n_i(rst_n), .reg_addr_i(ad), .reg_wdata_i(wd),
		.reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdata), .trig_key_i(pin[0]),
		.trig_ext_i(pin[2]), .trig_int_i(pin[3]), .gate_i(gate), .src_data_i(sdata),
		.src_seg_end_i(sseg), .src_seq_end_i(sseq), .src_valid_i(sval), .src_ready_o(sready),
		.smp_data_o(smp), .smp_valid_o(smp_v), .smp_ready_i(rdy), .rewind_o(rew),
		.playing_o(play), .clk_ext_sel_o(), .smp_rate_o(rate)
	);
	arbt_src_model #(.SEQ(SEQ), .SEG(SEG)) i_src
	(
		.clock_i(clk), .reset_n_i(rst_n), .rewind_i(rew), .ready_i(sready),
		.data_o(sdata), .valid_o(sval), .seg_end_o(sseg), .seq_end_o(sseq)
	);
	always #10 clk = ~clk;
	function automatic [31:0] kept(input [31:0] old, input [31:0] w);
		kept = (w >= 32'h00000064 && w <= 32'h0EE6B280) ? w : old;
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want)
		begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task conclude;
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clk);
		ad <= a;
		wd <= d;
		we <= 1;
		@(posedge clk);
		we <= 0;
		// let the monitor finish this edge before callers snapshot counters
		#1;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		@(posedge clk);
		ad <= a;
		re <= 1;
		@(posedge clk);
		re <= 0;
		#1 chk(rdata, e);
	endtask
	task hold(input int n, input logic e);
		repeat (n) @(posedge clk);
		#1 chk({31'h0, play}, {31'h0, e});
	endtask
	task wp(input logic e);
		#1;
		for (i = 0; i < 40 && play !== e; i++)
			@(posedge clk) #1;
		hold(0, e);
	endtask
	// pins held several cycles so the synchronisers see a clean rise
	task fire(input int k);
		if (k == 1)
			wr(8'h08, 32'h00000001);
		else
		begin
			@(posedge clk);
			pin[k] <= 1;
			repeat (4) @(posedge clk);
			pin[k] <= 0;
		end
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			conclude;
		end
		rdy <= ($urandom % 4) != 0;
		if (rew)
		begin
			exp_idx = 16'h0000;
			rews++;
		end
		else if (smp_v && rdy)
		begin
			chk({16'h0000, smp}, {16'h0000, exp_idx});
			exp_idx = (exp_idx == SEQ - 1) ? 16'h0000 : exp_idx + 16'h0001;
			words++;
		end
	end
	initial
	begin
		s = $urandom(23641);
		vals = '{32'h00000063, 32'h00000064, 32'h0EE6B280, 32'h0EE6B281, 32'h00000000};
		vals[4] = 32'h00000064 + $urandom % 32'h0EE6B21D;
		repeat (3) @(posedge clk);
		rst_n <= 1;
		rd(8'h00, 32'h00000000);
		rd(8'h04, 32'h0BEBC200);
		rd(8'h10, 32'h0BEBC200);
		rd(8'h14, 32'h00000000);
		wr(8'h00, 32'h000007EA);
		rd(8'h00, 32'h000007EA);
		for (s = 0; s < 5; s++)
		begin
			wr(8'h04, vals[s]);
			cur = kept(cur, vals[s]);
			rd(8'h04, cur);
		end
		rd(8'h10, cur);
		wr(8'h00, 32'h00000100);
		rd(8'h10, 32'h0BEBC200);
		hold(20, 0);
		wr(8'h08, 32'h00000002);
		wp(1);
		hold(30, 1);
		r0 = rews;
		fire(1);
		hold(10, 1);
		chk(rews - r0, 0);
		wr(8'h00, 32'h00000111);
		hold(20, 0);
		w0 = words;
		fire(1);
		wp(1);
		fire(1);
		wp(0);
		hold(10, 0);
		chk(words - w0, SEQ);
		wr(8'h00, 32'h00000108);
		w0 = words;
		hold(20, 0);
		chk(words - w0, 0);
		fire(1);
		wp(1);
		hold(40, 1);
		r0 = rews;
		fire(1);
		hold(8, 1);
		chk(rews - r0, 1);
		wr(8'h00, 32'h00000101);
		w0 = words;
		wp(1);
		wp(0);
		fire(1);
		hold(10, 0);
		chk(words - w0, SEQ);
		rd(8'h0C, 32'h00000007);
		wr(8'h00, 32'h00000102);
		w0 = words;
		fire(1);
		wp(1);
		wp(0);
		hold(10, 0);
		chk(words - w0, SEG);
		wr(8'h00, 32'h00000142);
		fire(1);
		wp(1);
		hold(50, 1);
		wr(8'h00, 32'h00000083);
		hold(20, 0);
		@(posedge clk) gate <= 1;
		wp(1);
		@(posedge clk) gate <= 0;
		wp(0);
		wr(8'h00, 32'h00000003);
		wp(1);
		for (s = 0; s < 4; s++)
		begin
			wr(8'h00, 32'h00000004 | (s << 8));
			hold(10, 0);
			fire((s + 1) % 4);
			hold(10, 0);
			fire(s);
			wp(1);
		end
		conclude;
	end
endmodule // tb
